// >>> design/itu_pkg.sv
package itu_pkg;
   // ----------------------------------------------------------------
   // command codes
   // ----------------------------------------------------------------
   localparam logic [11:0] SEL_ONESHOT0 = 12'h000;
   localparam logic [11:0] SEL_SCHED0   = 12'h003;
   localparam logic [11:0] SEL_READ0    = 12'h006;
   localparam logic [11:0] SEL_STOP0    = 12'h009;
   localparam logic [11:0] SEL_STOP2    = 12'h00B;
   localparam logic [11:0] CTL_MASK_ALL = 12'h100;
   localparam logic [11:0] CTL_UNMASK   = 12'h200;
   // ----------------------------------------------------------------
   // limits and timing
   // ----------------------------------------------------------------
   localparam logic [15:0] TICK_MIN     = 16'h0005;
   localparam logic [15:0] TICK_MAX     = 16'h0320;
   localparam logic [15:0] TICK_CONST   = 16'h0010;
   localparam logic [15:0] SUB_MAX      = 16'h0255;
   localparam logic [15:0] BCD_ZERO     = 16'h0000;
   localparam int          CLK_MHZ      = 100;
   localparam int          BASE_US      = 100;
   localparam int          BASE_CYCLES  = CLK_MHZ * BASE_US;
   localparam int          NTIMERS      = 3;
   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [11:0] sel;
      logic [15:0] word0;
      logic [15:0] word1;
      logic        is_const;
      logic [15:0] sub_no;
   } itu_cmd_t;
   typedef struct packed {
      logic [15:0] dec_count;
      logic [15:0] interval;
      logic [15:0] since;
   } itu_elapsed_t;
   typedef enum logic [1:0] {
      TM_STOPPED,
      TM_ONESHOT,
      TM_SCHED
   } itu_mode_t;
endpackage

// >>> design/itu_timer_unit.sv
`timescale 1ns/10ps
module itu_timer_unit #(
   parameter int BASE_CYCLES = itu_pkg::BASE_CYCLES
) (
   input  wire logic                 clk,
   input  wire logic                 srst,
   input  wire logic                 cmd_valid,
   input  itu_pkg::itu_cmd_t         cmd,
   input  wire logic                 in_isr,
   input  wire logic                 hsc0_active,
   input  wire logic                 pulse_out_active,
   input  wire logic [2:0]           timer_mask,
   input  wire logic                 irq_ack,
   output logic                      cmd_error,
   output logic                      rd_valid,
   output itu_pkg::itu_elapsed_t     rd_data,
   output logic                      group_mask,
   output logic [2:0]                pending,
   output logic                      irq_valid,
   output logic [1:0]                irq_timer,
   output logic [7:0]                irq_sub
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] bcd_inc(input logic [15:0] v);
      logic [15:0] r;
      logic        c;
      r = v;
      c = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (c) begin
            if (r[i*4 +: 4] == 4'h9) begin
               r[i*4 +: 4] = 4'h0;
            end else begin
               r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
               c = 1'b0;
            end
         end
      end
      return r;
   endfunction
   function automatic logic [15:0] bcd_dec(input logic [15:0] v);
      logic [15:0] r;
      logic        b;
      r = v;
      b = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (b) begin
            if (r[i*4 +: 4] == 4'h0) begin
               r[i*4 +: 4] = 4'h9;
            end else begin
               r[i*4 +: 4] = r[i*4 +: 4] - 4'h1;
               b = 1'b0;
            end
         end
      end
      return r;
   endfunction
   function automatic logic bcd_ok(input logic [15:0] v);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (v[i*4 +: 4] > 4'h9) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction
   function automatic logic [7:0] bcd_to_bin(input logic [15:0] v);
      return 8'(v[11:8] * 7'd100 + v[7:4] * 4'd10 + v[3:0]);
   endfunction
   // ----------------------------------------------------------------
   // 0.1 ms timebase
   // ----------------------------------------------------------------
   logic [15:0] base_cnt_q;
   logic        base_tick;
   assign base_tick = (base_cnt_q == 16'(BASE_CYCLES - 1));
   always_ff @(posedge clk) begin
      if (srst) begin
         base_cnt_q <= 16'h0000;
      end else if (base_tick) begin
         base_cnt_q <= 16'h0000;
      end else begin
         base_cnt_q <= base_cnt_q + 16'h0001;
      end
   end
   // ----------------------------------------------------------------
   // command decode
   // ----------------------------------------------------------------
   logic        is_start;
   logic        is_sched;
   logic        is_read;
   logic        is_stop;
   logic [1:0]  tsel;
   logic [15:0] iv_eff;
   logic        busy_conflict;
   logic        start_ok;
   always_comb begin
      is_start = cmd_valid && (cmd.sel < itu_pkg::SEL_READ0);
      is_sched = (cmd.sel >= itu_pkg::SEL_SCHED0);
      is_read  = cmd_valid && (cmd.sel >= itu_pkg::SEL_READ0) && (cmd.sel < itu_pkg::SEL_STOP0);
      is_stop  = cmd_valid && (cmd.sel >= itu_pkg::SEL_STOP0) && (cmd.sel <= itu_pkg::SEL_STOP2);
      tsel     = 2'(cmd.sel % 12'h003);
      iv_eff   = cmd.is_const ? itu_pkg::TICK_CONST : cmd.word1;
      busy_conflict = (tsel == 2'd2 && hsc0_active)
                   || (tsel == 2'd0 && pulse_out_active);
      start_ok = bcd_ok(cmd.word0)
              && bcd_ok(iv_eff) && iv_eff >= itu_pkg::TICK_MIN
              && iv_eff <= itu_pkg::TICK_MAX
              && bcd_ok(cmd.sub_no) && cmd.sub_no <= itu_pkg::SUB_MAX
              && !busy_conflict;
   end
   // ----------------------------------------------------------------
   // group mask
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         group_mask <= 1'b0;
      end else if (cmd_valid && !in_isr && cmd.sel == itu_pkg::CTL_MASK_ALL) begin
         group_mask <= 1'b1;
      end else if (cmd_valid && !in_isr && cmd.sel == itu_pkg::CTL_UNMASK) begin
         group_mask <= 1'b0;
      end
   end
   // ----------------------------------------------------------------
   // timers
   // ----------------------------------------------------------------
   itu_pkg::itu_mode_t mode_q [itu_pkg::NTIMERS];
   logic [15:0] sv_q    [itu_pkg::NTIMERS];
   logic [15:0] pv_q    [itu_pkg::NTIMERS];
   logic [15:0] iv_q    [itu_pkg::NTIMERS];
   logic [15:0] since_q [itu_pkg::NTIMERS];
   logic [15:0] ndec_q  [itu_pkg::NTIMERS];
   logic [7:0]  sub_q   [itu_pkg::NTIMERS];
   logic [2:0]  expire;
   logic [2:0]  run;
   logic [2:0]  load;
   logic [2:0]  halt;
   logic [2:0]  wrap;
   always_comb begin
      for (int t = 0; t < itu_pkg::NTIMERS; t++) begin
         run[t]    = (mode_q[t] != itu_pkg::TM_STOPPED);
         load[t]   = is_start && start_ok && tsel == 2'(t);
         halt[t]   = is_stop && tsel == 2'(t);
         wrap[t]   = run[t] && base_tick && (bcd_inc(since_q[t]) == iv_q[t]);
         expire[t] = wrap[t]
                  && (pv_q[t] == 16'h0001 || pv_q[t] == itu_pkg::BCD_ZERO);
      end
   end
   // ----------------------------------------------------------------
   // timer mode
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         for (int t = 0; t < itu_pkg::NTIMERS; t++) begin
            mode_q[t] <= itu_pkg::TM_STOPPED;
         end
      end else begin
         for (int t = 0; t < itu_pkg::NTIMERS; t++) begin
            if (load[t]) begin
               mode_q[t] <= is_sched ? itu_pkg::TM_SCHED : itu_pkg::TM_ONESHOT;
            end else if (halt[t]) begin
               mode_q[t] <= itu_pkg::TM_STOPPED;
            end else if (expire[t] && mode_q[t] == itu_pkg::TM_ONESHOT) begin
               mode_q[t] <= itu_pkg::TM_STOPPED;
            end
         end
      end
   end
   // ----------------------------------------------------------------
   // timer settings
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         for (int t = 0; t < itu_pkg::NTIMERS; t++) begin
            sv_q[t]  <= 16'h0000;
            iv_q[t]  <= itu_pkg::TICK_CONST;
            sub_q[t] <= 8'h00;
         end
      end else begin
         for (int t = 0; t < itu_pkg::NTIMERS; t++) begin
            if (load[t]) begin
               sv_q[t]  <= cmd.word0;
               iv_q[t]  <= iv_eff;
               sub_q[t] <= bcd_to_bin(cmd.sub_no);
            end
         end
      end
   end
   // ----------------------------------------------------------------
   // present value and decrement count
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         for (int t = 0; t < itu_pkg::NTIMERS; t++) begin
            pv_q[t]   <= 16'h0000;
            ndec_q[t] <= 16'h0000;
         end
      end else begin
         for (int t = 0; t < itu_pkg::NTIMERS; t++) begin
            if (load[t]) begin
               pv_q[t]   <= cmd.word0;
               ndec_q[t] <= 16'h0000;
            end else if (halt[t]) begin
               ndec_q[t] <= 16'h0000;
            end else if (expire[t]) begin
               pv_q[t]   <= (mode_q[t] == itu_pkg::TM_SCHED) ? sv_q[t] : 16'h0000;
               ndec_q[t] <= 16'h0000;
            end else if (wrap[t]) begin
               pv_q[t]   <= bcd_dec(pv_q[t]);
               ndec_q[t] <= bcd_inc(ndec_q[t]);
            end
         end
      end
   end
   // ----------------------------------------------------------------
   // time since last decrement
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         for (int t = 0; t < itu_pkg::NTIMERS; t++) begin
            since_q[t] <= 16'h0000;
         end
      end else begin
         for (int t = 0; t < itu_pkg::NTIMERS; t++) begin
            if (load[t] || halt[t] || wrap[t]) begin
               since_q[t] <= 16'h0000;
            end else if (run[t] && base_tick) begin
               since_q[t] <= bcd_inc(since_q[t]);
            end
         end
      end
   end
   // ----------------------------------------------------------------
   // pending record and service
   // ----------------------------------------------------------------
   logic       servable;
   logic [1:0] pick;
   logic [2:0] eligible;
   always_comb begin
      eligible = pending & ~timer_mask;
      servable = !group_mask && (eligible != 3'b000);
      pick = eligible[0] ? 2'd0 : (eligible[1] ? 2'd1 : 2'd2);
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         pending <= 3'b000;
      end else begin
         for (int t = 0; t < itu_pkg::NTIMERS; t++) begin
            if (expire[t]) begin
               pending[t] <= 1'b1;
            end else if (irq_valid && irq_ack && irq_timer == 2'(t)) begin
               pending[t] <= 1'b0;
            end else if (is_stop && tsel == 2'(t)) begin
               pending[t] <= 1'b0;
            end
         end
      end
   end
   // ----------------------------------------------------------------
   // interrupt presentation
   // ----------------------------------------------------------------
   assign irq_valid = servable;
   always_ff @(posedge clk) begin
      if (srst) begin
         irq_timer <= 2'd0;
         irq_sub   <= 8'h00;
      end else begin
         irq_timer <= servable ? pick : irq_timer;
         irq_sub   <= servable ? sub_q[pick] : irq_sub;
      end
   end
   // ----------------------------------------------------------------
   // elapsed read
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         rd_valid <= 1'b0;
         rd_data  <= '0;
      end else begin
         rd_valid <= is_read;
         if (is_read) begin
            if (mode_q[tsel] == itu_pkg::TM_STOPPED) begin
               rd_data <= '0;
            end else begin
               rd_data.dec_count <= ndec_q[tsel];
               rd_data.interval  <= iv_q[tsel];
               rd_data.since     <= since_q[tsel];
            end
         end
      end
   end
   // ----------------------------------------------------------------
   // start errors
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         cmd_error <= 1'b0;
      end else begin
         cmd_error <= is_start && !start_ok;
      end
   end
endmodule

// >>> verif/itu_timer_unit_asserts.sv
`timescale 1ns/10ps
module itu_timer_unit_asserts #(
   parameter int BASE_CYCLES = itu_pkg::BASE_CYCLES
) (
   input  wire logic            clk,
   input  wire logic            srst,
   input  wire logic            cmd_valid,
   input  itu_pkg::itu_cmd_t     cmd,
   input  wire logic            in_isr,
   input  wire logic            hsc0_active,
   input  wire logic            pulse_out_active,
   input  wire logic [2:0]      timer_mask,
   input  wire logic            irq_ack,
   input  wire logic            cmd_error,
   input  wire logic            rd_valid,
   input  itu_pkg::itu_elapsed_t rd_data,
   input  wire logic            group_mask,
   input  wire logic [2:0]      pending,
   input  wire logic            irq_valid,
   input  wire logic [1:0]      irq_timer,
   input  wire logic [7:0]      irq_sub
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   sequence s_ctl(logic [11:0] code);
      cmd_valid && !in_isr && cmd.sel == code;
   endsequence
   sequence s_sel(logic [11:0] a, logic [11:0] b);
      cmd_valid && (cmd.sel == a || cmd.sel == b);
   endsequence
   sequence s_ready;
      !group_mask && (pending & ~timer_mask) != 3'h0;
   endsequence
   mask_set_a: assert property (s_ctl(12'h100) |=> group_mask)
      else $error("group mask not set");
   mask_clear_a: assert property (s_ctl(12'h200) |=> !group_mask)
      else $error("group mask not cleared");
   isr_ignore_a: assert property (cmd_valid && in_isr |=> group_mask == $past(group_mask))
      else $error("group mask moved inside routine");
   irq_gate_a: assert property (irq_valid |-> s_ready)
      else $error("interrupt presented while masked");
   irq_serve_a: assert property (s_ready |-> irq_valid)
      else $error("recorded interrupt not presented");
   hsc_excl_a: assert property (s_sel(12'h002, 12'h005) ##0 hsc0_active |=> cmd_error)
      else $error("timer 2 start not refused");
   pulse_excl_a: assert property (s_sel(12'h000, 12'h003) ##0 pulse_out_active
      |=> cmd_error) else $error("timer 0 start not refused");
   read_ans_a: assert property (cmd_valid && cmd.sel inside {[12'h006:12'h008]} |=> rd_valid)
      else $error("elapsed read not answered");
   since_below_a: assert property (rd_valid && rd_data.interval != 16'h0000
      |-> rd_data.since < rd_data.interval) else $error("time since decrement too large");
endmodule
bind itu_timer_unit itu_timer_unit_asserts #(.BASE_CYCLES(BASE_CYCLES)) chk_u (
   .clk(clk), .srst(srst), .cmd_valid(cmd_valid), .cmd(cmd), .in_isr(in_isr),
   .hsc0_active(hsc0_active), .pulse_out_active(pulse_out_active), .timer_mask(timer_mask),
   .irq_ack(irq_ack), .cmd_error(cmd_error), .rd_valid(rd_valid), .rd_data(rd_data),
   .group_mask(group_mask), .pending(pending), .irq_valid(irq_valid),
   .irq_timer(irq_timer), .irq_sub(irq_sub));

// >>> verif/itu_timer_unit_tb_top.sv
`timescale 1ns/10ps
module itu_timer_unit_tb_top;
   logic                  clk = 1'b0;
   logic                  srst = 1'b1;
   logic                  cmd_valid = 1'b0;
   itu_pkg::itu_cmd_t     cmd = '0;
   logic                  in_isr = 1'b0;
   logic                  hsc0_active = 1'b0;
   logic                  pulse_out_active = 1'b0;
   logic [2:0]            timer_mask = 3'h0;
   logic                  irq_ack = 1'b0;
   logic                  cmd_error, rd_valid, group_mask, irq_valid;
   itu_pkg::itu_elapsed_t rd_data;
   logic [2:0]            pending;
   logic [1:0]            irq_timer;
   logic [7:0]            irq_sub;
   logic [51:0]           exp_q[$];
   logic                  irq_vd = 1'b0;
   logic                  ack_now = 1'b0;
   logic [31:0]           seed = 32'h00013F8F;
   int                    n_mismatch = 0;
   int                    checked = 0;
   int                    i;
   int                    j;
   // ----------------------------------------------------------------
   // clock, design, tasks
   // ----------------------------------------------------------------
   initial forever #5 clk = ~clk;
   itu_timer_unit #(.BASE_CYCLES(10)) dut_u (
      .clk(clk), .srst(srst), .cmd_valid(cmd_valid), .cmd(cmd), .in_isr(in_isr),
      .hsc0_active(hsc0_active), .pulse_out_active(pulse_out_active),
      .timer_mask(timer_mask), .irq_ack(irq_ack), .cmd_error(cmd_error),
      .rd_valid(rd_valid), .rd_data(rd_data), .group_mask(group_mask), .pending(pending),
      .irq_valid(irq_valid), .irq_timer(irq_timer), .irq_sub(irq_sub));
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task summarize;
      if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task check(input string what, input logic [51:0] seen, input logic [51:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task seen_ev(input logic [51:0] v);
      if (exp_q.size() == 0) check("event", v, 'x);
      else check("event", v, exp_q.pop_front());
   endtask
   task send(input logic [11:0] sel, input logic [15:0] w0, w1, input logic c,
             input logic [15:0] sub);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd <= '{sel, w0, w1, c, sub};
      @(posedge clk);
      cmd_valid <= 1'b0;
   endtask
   task bad(input logic [11:0] sel, input logic [15:0] w0, w1, sub);
      exp_q.push_back({4'h1, 48'h0});
      send(sel, w0, w1, 1'b0, sub);
   endtask
   task start(input logic [11:0] sel, input logic [15:0] w0, w1, input logic c,
              input logic [1:0] tmr, input int n);
      logic [3:0] d;
      seed = lfsr_next(seed);
      d = 4'(seed % 10);
      repeat (n) exp_q.push_back({4'h3, 38'h0, tmr, 4'h0, d});
      send(sel, w0, w1, c, {12'h000, d});
   endtask
   task drain(input int limit);
      for (i = 0; i < limit && exp_q.size() != 0; i++) @(posedge clk);
      if (exp_q.size() != 0) begin
         n_mismatch++;
         summarize();
      end
   endtask
   // ----------------------------------------------------------------
   // monitor and interrupt acknowledge
   // ----------------------------------------------------------------
   always @(negedge clk) begin
      ack_now = !srst && irq_valid === 1'b1 && irq_vd && !irq_ack;
      if (!srst && cmd_error === 1'b1) seen_ev({4'h1, 48'h0});
      if (!srst && rd_valid === 1'b1) seen_ev({4'h2, rd_data});
      if (ack_now) seen_ev({4'h3, 38'h0, irq_timer, irq_sub});
      irq_vd = irq_valid === 1'b1 && !irq_ack;
   end
   always @(posedge clk) irq_ack <= ack_now;
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      for (j = 0; j < 3; j++) begin
         exp_q.push_back({4'h2, 48'h0});
         send(12'h006 + 12'(j), 16'h0, 16'h0, 1'b0, 16'h0);
      end
      @(posedge clk) hsc0_active <= 1'b1;
      bad(12'h002, 16'h0002, itu_pkg::TICK_MIN, 16'h0001);
      bad(12'h005, 16'h0002, itu_pkg::TICK_MIN, 16'h0001);
      @(posedge clk) hsc0_active <= 1'b0;
      pulse_out_active <= 1'b1;
      bad(12'h000, 16'h0002, itu_pkg::TICK_MIN, 16'h0001);
      bad(12'h003, 16'h0002, itu_pkg::TICK_MIN, 16'h0001);
      @(posedge clk) pulse_out_active <= 1'b0;
      bad(12'h001, 16'h0002, 16'h0004, 16'h0001);
      bad(12'h001, 16'h0002, 16'h0321, 16'h0001);
      bad(12'h001, 16'h00A0, itu_pkg::TICK_MIN, 16'h0001);
      bad(12'h001, 16'h0002, itu_pkg::TICK_MIN, 16'h0256);
      drain(20);
      for (j = 0; j < 3; j++) begin
         start(12'(j), 16'h0002, itu_pkg::TICK_MIN, 1'b0, 2'(j), 1);
         drain(400);
         repeat (300) @(posedge clk);
         start(12'h003 + 12'(j), 16'h0001, itu_pkg::TICK_MIN, 1'b0, 2'(j), 2);
         drain(400);
         exp_q.push_back({4'h2, 16'h0000, itu_pkg::TICK_MIN, 16'h0000});
         send(12'h006 + 12'(j), 16'h0, 16'h0, 1'b0, 16'h0);
         send(12'h009 + 12'(j), 16'h0, 16'h0, 1'b0, 16'h0);
         exp_q.push_back({4'h2, 48'h0});
         send(12'h006 + 12'(j), 16'h0, 16'h0, 1'b0, 16'h0);
         repeat (200) @(posedge clk);
      end
      start(12'h000, 16'h0001, 16'h0000, 1'b1, 2'h0, 1);
      drain(400);
      @(posedge clk) in_isr <= 1'b1;
      send(12'h100, 16'h0, 16'h0, 1'b0, 16'h0);
      @(posedge clk) in_isr <= 1'b0;
      @(negedge clk);
      check("group_mask", {51'h0, group_mask}, 52'h0);
      @(posedge clk) timer_mask <= 3'h4;
      send(12'h100, 16'h0, 16'h0, 1'b0, 16'h0);
      send(12'h002, 16'h0001, itu_pkg::TICK_MIN, 1'b0, 16'h0);
      repeat (200) @(posedge clk);
      @(negedge clk);
      check("pending", {49'h0, pending}, 52'h4);
      check("group_mask", {51'h0, group_mask}, 52'h1);
      send(12'h200, 16'h0, 16'h0, 1'b0, 16'h0);
      @(negedge clk);
      check("group_mask", {51'h0, group_mask}, 52'h0);
      check("irq_valid", {51'h0, irq_valid}, 52'h0);
      exp_q.push_back({4'h3, 38'h0, 2'h2, 8'h00});
      @(posedge clk) timer_mask <= 3'h0;
      drain(50);
      summarize();
   end
endmodule
